// ==== rrs_pkg.sv ====
package rrs_pkg;

    // ==========================================================
    // bus and register map
    // ==========================================================
    localparam int ADDR_W = 12;                          // apb byte address width
    localparam logic [11:0] OFF_INSTR = 12'h000;         // write executes an opcode
    localparam logic [11:0] OFF_WORK = 12'h004;          // working register
    localparam logic [11:0] OFF_BANK = 12'h008;          // bank_selector_reg
    localparam logic [11:0] OFF_STATUS = 12'h00c;        // negative and zero flags
    localparam logic [11:0] OFF_PTR = 12'h010;           // file pointer for software access
    localparam logic [11:0] OFF_DATA = 12'h014;          // file byte at pointer
    localparam int STAT_ZERO_BIT = 0;                    // zero flag position
    localparam int STAT_NEG_BIT = 1;                     // negative flag position

    // ==========================================================
    // instruction encoding
    // ==========================================================
    localparam logic [5:0] ROT_PREFIX = 6'h10;           // 010000 d a ffffffff
    localparam logic [6:0] FILL_PREFIX = 7'h34;          // 0110100 a ffffffff
    localparam int DEST_BIT = 9;                         // destination select position
    localparam int BANK_BIT = 8;                         // bank access position
    localparam logic [7:0] FILL_VALUE = 8'hff;           // value written by the fill op

    // ==========================================================
    // data memory
    // ==========================================================
    localparam int FILE_AW = 12;                         // bank nibble plus byte
    localparam int FILE_DEPTH = 4096;                    // bytes held
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;         // access bank low/high boundary
    localparam logic [3:0] ACC_LOW_BANK = 4'h0;          // low half of access bank
    localparam logic [3:0] ACC_HIGH_BANK = 4'hf;         // high half of access bank

    // ==========================================================
    // types
    // ==========================================================
    typedef enum logic [1:0] {
        PH_IDLE = 2'b01,
        PH_ACK = 2'b10
    } rrs_phase_type;

    typedef enum logic [1:0] {
        ALU_ROTATE = 2'b01,
        ALU_FILL = 2'b10
    } rrs_aluop_type;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } rrs_apb_req_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } rrs_apb_rsp_type;

    typedef struct packed {
        logic [7:0] value;
        logic neg;
        logic zero;
    } rrs_alu_out_type;

endpackage

// ==== rrs_alu.sv ====
`timescale 1ns/1ps
// ==========================================================
// result and flag computation, purely combinational
// ==========================================================
module rrs_alu
    import rrs_pkg::*;
(
    input wire rrs_pkg::rrs_aluop_type op,      // which operation
    input wire logic [7:0] operand,             // byte read from the file
    output rrs_pkg::rrs_alu_out_type result     // value and flags
);

    // one small mux, flags always derived from the value
    always_comb begin
        result = '0;
        case (op)
            ALU_ROTATE: begin
                result.value = {operand[0], operand[7:1]};
            end
            ALU_FILL: begin
                result.value = FILL_VALUE;
            end
            default: begin
                result.value = operand;
            end
        endcase
        result.neg = result.value[7];
        result.zero = (result.value == 8'h00);
    end

endmodule // rrs_alu

// ==== rrs_core.sv ====
`timescale 1ns/1ps
// ==========================================================
// rotate / fill datapath with apb register access
// ==========================================================
module rrs_core
    import rrs_pkg::*;
(
    input wire logic core_clk,                   // 10 mhz core clock
    input wire logic arst_n,                     // async reset, active low
    input wire rrs_pkg::rrs_apb_req_type apbReq, // apb request group
    output rrs_pkg::rrs_apb_rsp_type apbRsp,     // apb answer group
    output logic [7:0] workValue,                // working register
    output logic negFlag,                        // negative flag
    output logic zeroFlag,                       // zero flag
    output logic [3:0] bankValue                 // bank_selector_reg contents
);
    import rrs_pkg::*;

    // ==========================================================
    // state
    // ==========================================================
    typedef struct packed {
        logic [FILE_DEPTH-1:0][7:0] mem; // file registers, flip-flops
        logic [7:0] work;                // working register
        logic [3:0] bank;                // bank_selector_reg
        logic neg;                       // negative flag
        logic zero;                      // zero flag
        logic [15:0] lastOp;             // last accepted opcode written
        logic [FILE_AW-1:0] ptr;         // software file pointer
        rrs_phase_type phase;            // apb handshake phase
        logic [31:0] prdata;             // read data held for the bus
        logic pready;                    // access phase done
        logic pslverr;                   // access refused
    } rrs_state_type;

    rrs_state_type s_reg; // registered state
    rrs_state_type s_next; // next state

    // ==========================================================
    // opcode decode, from the write data of the current transfer
    // ==========================================================
    logic [15:0] opWord;            // opcode bits
    logic isRotate;                 // rotate right plain op
    logic isFill;                   // fill ones op
    logic destFile;                 // destination select bit
    logic bankAccess;               // bank access bit
    logic [7:0] fileByte;           // low byte file address
    logic [FILE_AW-1:0] fileAddr;   // full file address
    rrs_aluop_type aluOp;           // operation into the alu
    rrs_alu_out_type aluOut;        // alu answer

    always_comb begin
        opWord = apbReq.pwdata[15:0];
        isRotate = (opWord[15:10] == ROT_PREFIX);
        isFill = (opWord[15:9] == FILL_PREFIX);
        destFile = opWord[DEST_BIT];
        bankAccess = opWord[BANK_BIT];
        fileByte = opWord[7:0];
    end

    // file address: access bank splits at the boundary between bank 0 and the top bank
    always_comb begin
        if (bankAccess) begin
            fileAddr = {s_reg.bank, fileByte};
        end else if (fileByte < ACCESS_SPLIT) begin
            fileAddr = {ACC_LOW_BANK, fileByte};
        end else begin
            fileAddr = {ACC_HIGH_BANK, fileByte};
        end
    end

    // fill takes precedence only because the prefixes never overlap
    always_comb begin
        aluOp = isFill ? ALU_FILL : ALU_ROTATE;
    end

    rrs_alu u_alu (
        .op(aluOp),
        .operand(s_reg.mem[fileAddr]),
        .result(aluOut)
    );

    // ==========================================================
    // next state
    // ==========================================================
    // the bus answer is prepared on entry to the access phase and the
    // write side effects happen at the edge where pready is seen high,
    // so every transfer takes exactly one wait state
    always_comb begin
        s_next = s_reg;
        s_next.pready = 1'b0;
        s_next.pslverr = 1'b0;
        case (s_reg.phase)
            PH_IDLE: begin
                // access phase seen: answer next cycle
                if (apbReq.psel && apbReq.penable) begin
                    s_next.phase = PH_ACK;
                    s_next.pready = 1'b1;
                    s_next.prdata = '0;
                    case (apbReq.paddr)
                        OFF_INSTR: begin
                            s_next.prdata = {16'h0000, s_reg.lastOp};
                            // unknown opcodes are refused, nothing executes
                            s_next.pslverr = apbReq.pwrite && !(isRotate || isFill);
                        end
                        OFF_WORK: begin
                            s_next.prdata = {24'h000000, s_reg.work};
                        end
                        OFF_BANK: begin
                            s_next.prdata = {28'h0000000, s_reg.bank};
                        end
                        OFF_STATUS: begin
                            s_next.prdata[STAT_NEG_BIT] = s_reg.neg;
                            s_next.prdata[STAT_ZERO_BIT] = s_reg.zero;
                        end
                        OFF_PTR: begin
                            s_next.prdata = {20'h00000, s_reg.ptr};
                        end
                        OFF_DATA: begin
                            s_next.prdata = {24'h000000, s_reg.mem[s_reg.ptr]};
                        end
                        default: begin
                            // unmapped: error, reads zero
                            s_next.pslverr = 1'b1;
                        end
                    endcase
                end
            end
            PH_ACK: begin
                // this edge completes the transfer
                s_next.phase = PH_IDLE;
                if (apbReq.pwrite && !s_reg.pslverr) begin
                    case (apbReq.paddr)
                        OFF_INSTR: begin
                            s_next.lastOp = opWord;
                            if (isRotate) begin
                                if (destFile) begin
                                    s_next.mem[fileAddr] = aluOut.value;
                                end else begin
                                    s_next.work = aluOut.value;
                                end
                                // only n and z move, nothing else is touched
                                s_next.neg = aluOut.neg;
                                s_next.zero = aluOut.zero;
                            end else if (isFill) begin
                                // flags deliberately left alone
                                s_next.mem[fileAddr] = aluOut.value;
                            end
                        end
                        OFF_WORK: begin
                            s_next.work = apbReq.pwdata[7:0];
                        end
                        OFF_BANK: begin
                            s_next.bank = apbReq.pwdata[3:0];
                        end
                        OFF_STATUS: begin
                            s_next.neg = apbReq.pwdata[STAT_NEG_BIT];
                            s_next.zero = apbReq.pwdata[STAT_ZERO_BIT];
                        end
                        OFF_PTR: begin
                            s_next.ptr = apbReq.pwdata[FILE_AW-1:0];
                        end
                        OFF_DATA: begin
                            s_next.mem[s_reg.ptr] = apbReq.pwdata[7:0];
                        end
                        default: begin
                            s_next.phase = PH_IDLE;
                        end
                    endcase
                end
            end
            default: begin
                // illegal phase code: recover to idle
                s_next.phase = PH_IDLE;
            end
        endcase
    end

    // ==========================================================
    // registers
    // ==========================================================
    // whole file clears at reset; costly in area but gives defined reads
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_reg <= '0;
            s_reg.phase <= PH_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    // ==========================================================
    // outputs, all straight from flip-flops
    // ==========================================================
    // one driver for the whole answer group, members are not driven apart
    assign apbRsp = '{prdata: s_reg.prdata, pready: s_reg.pready, pslverr: s_reg.pslverr};
    assign workValue = s_reg.work;
    assign negFlag = s_reg.neg;
    assign zeroFlag = s_reg.zero;
    assign bankValue = s_reg.bank;

endmodule // rrs_core

// ==== rrs_core_checker.sv ====
`timescale 1ns/1ps
// ==========================================================
// port checks of the rotate/fill core
// ==========================================================
module rrs_core_checker
    import rrs_pkg::*;
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire rrs_pkg::rrs_apb_req_type apbReq,
    input wire rrs_pkg::rrs_apb_rsp_type apbRsp,
    input wire logic [7:0] workValue,
    input wire logic negFlag,
    input wire logic zeroFlag,
    input wire logic [3:0] bankValue
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    // completing write and opcode class
    wire logic wrDone = apbReq.psel && apbReq.penable && apbReq.pwrite && apbRsp.pready;
    wire logic instr = wrDone && (apbReq.paddr == OFF_INSTR);
    wire logic isRot = apbReq.pwdata[15:10] == ROT_PREFIX;
    wire logic isFill = apbReq.pwdata[15:9] == FILL_PREFIX;
    AST_ONE_WAIT: assert property (apbReq.psel && apbReq.penable && !apbRsp.pready |=>
        apbRsp.pready) else $error("pready not one cycle after access");
    AST_PULSE: assert property (apbRsp.pready |=> !apbRsp.pready)
        else $error("pready held too long");
    AST_ERR_QUAL: assert property (apbRsp.pslverr |-> apbRsp.pready)
        else $error("pslverr without pready");
    AST_W_HOLD: assert property (!wrDone |=> $stable(workValue))
        else $error("working register moved without a write");
    AST_FLAG_HOLD: assert property (!wrDone |=> $stable({negFlag, zeroFlag}))
        else $error("flags moved without a write");
    AST_ROT_FLAGS: assert property (instr && isRot && !apbReq.pwdata[DEST_BIT] |=>
        negFlag == workValue[7] && zeroFlag == (workValue == 8'h00))
        else $error("rotate flags disagree with result");
    AST_FILL_QUIET: assert property (instr && isFill |->
        !apbRsp.pslverr ##1 $stable({negFlag, zeroFlag, workValue}))
        else $error("fill touched flags or work");
    AST_BAD_OP: assert property (instr && !isRot && !isFill |->
        apbRsp.pslverr ##1 $stable({negFlag, zeroFlag, workValue, bankValue}))
        else $error("bad opcode accepted");
    AST_BANK: assert property (wrDone && apbReq.paddr == OFF_BANK |=>
        bankValue == $past(apbReq.pwdata[3:0])) else $error("bank write lost");
    // main scenarios reached
    cover property (instr && isRot);
    cover property (instr && isFill);
    cover property (wrDone && apbRsp.pslverr);
endmodule // rrs_core_checker

bind rrs_core rrs_core_checker chk_u (.core_clk(core_clk), .arst_n(arst_n), .apbReq(apbReq),
    .apbRsp(apbRsp), .workValue(workValue), .negFlag(negFlag), .zeroFlag(zeroFlag),
    .bankValue(bankValue));

// ==== rrs_core_test.sv ====
`timescale 1ns/1ps
// ==========================================================
// randomized bench of the rotate/fill core
// ==========================================================
module rrs_core_test;
    import rrs_pkg::*;
    logic core_clk = 1'b0; // 10 mhz
    logic arst_n = 1'b0; // reset asserted at start
    rrs_apb_req_type apbReq = '0; // bus request
    rrs_apb_rsp_type apbRsp; // bus answer
    logic [7:0] workValue; // observed work
    logic negFlag; // observed n
    logic zeroFlag; // observed z
    logic [3:0] bankValue; // observed bank
    int errors = 0;
    int n_compared = 0;
    int cyc = 0; // timeout counter
    int seed = 1241;
    logic [31:0] rd; // last read data
    logic er; // last pslverr
    always #50 core_clk = ~core_clk;
    rrs_core dut_u (.core_clk(core_clk), .arst_n(arst_n), .apbReq(apbReq), .apbRsp(apbRsp),
        .workValue(workValue), .negFlag(negFlag), .zeroFlag(zeroFlag), .bankValue(bankValue));
    // one compare, counted
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // apb cycle; answer taken at the pready edge only
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge core_clk);
        apbReq.penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (apbRsp.pready !== 1'b1);
        rd = apbRsp.prdata;
        er = apbRsp.pslverr;
        apbReq.psel <= 1'b0;
        apbReq.penable <= 1'b0;
    endtask
    // expected file address; access bank splits low/high
    function automatic logic [11:0] faddr(input logic a, input logic [3:0] b, input logic [7:0] f);
        if (a) return {b, f};
        return {(f < ACCESS_SPLIT) ? ACC_LOW_BANK : ACC_HIGH_BANK, f};
    endfunction
    // hang guard, far above the ~2400 cycles needed
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            final_report();
        end
    end
    initial begin
        logic [7:0] f, v, w, r, expW, expF;
        logic [3:0] b;
        logic a, d, n, z;
        int k;
        logic [15:0] op, lastOk;
        repeat (5) @(posedge core_clk);
        arst_n <= 1'b1;
        @(negedge core_clk);
        chk("reset outs", {apbRsp.pready, apbRsp.pslverr, workValue, negFlag, zeroFlag, bankValue},
            32'h0);
        xfer(1'b1, OFF_WORK, 32'h1a5);
        xfer(1'b0, OFF_WORK, 32'h0);
        chk("work read", rd, 32'ha5);
        xfer(1'b0, 12'h018, 32'h0);
        chk("unmapped", {er, rd[30:0]}, 32'h80000000);
        $display("test registers done");
        // last accepted opcode, zero until the first one lands
        lastOk = 16'h0000;
        // first cases pin the access split and zero/negative results
        for (int i = 0; i < 60; i++) begin
            f = (i < 2) ? 8'h5f + i[7:0] : 8'($random(seed));
            v = (i == 2) ? 8'h01 : (i == 3) ? 8'h00 : 8'($random(seed));
            w = 8'($random(seed));
            b = 4'($random(seed));
            a = (i < 2) ? 1'b0 : 1'($random(seed));
            d = (i < 4) ? 1'b0 : 1'($random(seed));
            k = (i < 4) ? 0 : ($random(seed) & 3);
            {n, z} = 2'($random(seed));
            xfer(1'b1, OFF_BANK, {28'h0, b});
            xfer(1'b1, OFF_WORK, {24'h0, w});
            xfer(1'b1, OFF_STATUS, {30'h0, n, z});
            xfer(1'b1, OFF_PTR, {20'h0, faddr(a, b, f)});
            xfer(1'b1, OFF_DATA, {24'h0, v});
            r = {v[0], v[7:1]};
            expW = w;
            expF = v;
            if (k == 1) begin
                op = {FILL_PREFIX, a, f};
                expF = FILL_VALUE;
            end else if (k == 2) begin
                op = {6'h00, d, a, f};
            end else begin
                op = {ROT_PREFIX, d, a, f};
                if (d) expF = r;
                else expW = r;
                n = r[7];
                z = (r == 8'h00);
            end
            xfer(1'b1, OFF_INSTR, {16'h0, op});
            @(negedge core_clk);
            chk("instr err", er, {31'h0, k == 2});
            chk("work", workValue, expW);
            chk("flags", {negFlag, zeroFlag}, {n, z});
            chk("bank", bankValue, b);
            xfer(1'b0, OFF_DATA, 32'h0);
            chk("file", rd, expF);
            // refused opcodes must not replace the last accepted one
            if (k != 2) begin
                lastOk = op;
            end
            xfer(1'b0, OFF_INSTR, 32'h0);
            chk("last op", rd, {16'h0, lastOk});
            xfer(1'b0, OFF_STATUS, 32'h0);
            chk("status read", rd, {30'h0, n, z});
            xfer(1'b0, OFF_PTR, 32'h0);
            chk("ptr read", rd, {20'h0, faddr(a, b, f)});
        end
        $display("test rotate and fill done");
        final_report();
    end
endmodule // rrs_core_test
